// >>> hw/srf_framer.sv
// Overview of operation
// - Start marker, then 16-bit payload length.
// - Sample report type byte is 0x83.
// - Report only if legacy=2 and remote 0xFFFE.
// - Sample reports forwarded only in API mode.
// - Sender short address at offset 4.
// - Offset 6 holds signal strength magnitude.
// - Options: bit1 broadcast, bit2 all PANs.
// - Offset 8 holds sample set count.
// - Mask: digital bits 0-8, analog 9-12.
// - Digital word only when digital mask nonzero.
// - Analog results follow, input 0 first.
// - Checksum is 0xFF minus sum from offset 3.
// - Command response type byte is 0x88.
// - Many responses may answer one request.
// - No response when frame identifier is zero.
// - Frame identifier echoed at offset 4.
// - Two command characters at offset 5.
// - Status byte at offset 7, codes 0-3.
// - Data omitted after set, returned on query.
`timescale 1ns/100ps
module srf_framer (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  // Register port
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  // Received sample report
  input  wire logic        SMP_REQ,
  input  wire logic [15:0] SMP_SRC_ADDR,
  input  wire logic [15:0] SMP_SRC_SHORT_SETTING,
  input  wire logic [7:0]  SMP_RSSI,
  input  wire logic [7:0]  SMP_OPTIONS,
  input  wire logic [7:0]  SMP_COUNT,
  input  wire logic [15:0] SMP_MASK,
  input  wire logic [15:0] SMP_DIGITAL,
  input  wire logic [63:0] SMP_ANALOG,
  output logic             SMP_READY,
  // Local command response
  input  wire logic        CMD_REQ,
  input  wire logic [7:0]  CMD_FRAME_ID,
  input  wire logic [15:0] CMD_NAME,
  input  wire logic [1:0]  CMD_STATUS,
  input  wire logic        CMD_IS_SET,
  input  wire logic [3:0]  CMD_DATA_LEN,
  input  wire logic [63:0] CMD_DATA,
  output logic             CMD_READY,
  // Serial byte stream toward the host
  output logic      [7:0]  TX_DATA,
  output logic             TX_VALID,
  input  wire logic        TX_READY
);

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  typedef struct packed {
    srf_pkg::srf_phase_e                    phase;
    logic [srf_pkg::BUF_BYTES-1:0][7:0]     frame;
    logic [4:0]                             len;
    logic [4:0]                             cnt;
    logic [7:0]                             sum;
    logic                                   is_smp;
    logic [7:0]                             tx_data;
    logic                                   tx_valid;
    logic                                   ready;
    logic [31:0]                            rd_data;
    logic                                   api_mode;
    logic [7:0]                             legacy_out;
    logic [7:0]                             sent;
    logic [7:0]                             dropped;
  } srf_state_s;

  srf_state_s st;
  srf_state_s next_st;

  always_comb begin
    logic [srf_pkg::BUF_BYTES-1:0][7:0] sbuf;
    logic [srf_pkg::BUF_BYTES-1:0][7:0] cbuf;
    logic [4:0]  sp;
    logic [4:0]  cp;
    logic [15:0] m;
    logic [15:0] dig;
    logic [15:0] lw;
    logic [3:0]  dlen;
    logic        slot;
    logic        smp_ok;
    logic        cmd_take;
    logic        smp_take;
    logic [7:0]  b;
    sbuf     = '0;
    cbuf     = '0;
    sp       = '0;
    cp       = '0;
    m        = '0;
    dig      = '0;
    lw       = '0;
    dlen     = '0;
    slot     = 1'b0;
    smp_ok   = 1'b0;
    cmd_take = 1'b0;
    smp_take = 1'b0;
    b        = '0;
    next_st  = st;

    // Sample report image, fields MSB first.
    m = SMP_MASK & srf_pkg::MASK_VALID;
    sbuf[srf_pkg::OFF_START]       = srf_pkg::START_MARKER;
    sbuf[srf_pkg::OFF_TYPE]        = srf_pkg::TYPE_SAMPLE;
    sbuf[srf_pkg::OFF_SMP_ADDR]    = SMP_SRC_ADDR[15:8];
    sbuf[srf_pkg::OFF_SMP_ADDR+1]  = SMP_SRC_ADDR[7:0];
    sbuf[srf_pkg::OFF_SMP_RSSI]    = SMP_RSSI;
    sbuf[srf_pkg::OFF_SMP_OPT]     =
      SMP_OPTIONS & srf_pkg::OPT_KEEP;
    sbuf[srf_pkg::OFF_SMP_COUNT]   = SMP_COUNT;
    sbuf[srf_pkg::OFF_SMP_MASK]    = m[15:8];
    sbuf[srf_pkg::OFF_SMP_MASK+1]  = m[7:0];
    sp = srf_pkg::OFF_SMP_DIG;
    if ((m & srf_pkg::MASK_DIGITAL) != 16'h0000) begin
      dig = SMP_DIGITAL & m & srf_pkg::MASK_DIGITAL;
      sbuf[sp]             = dig[15:8];
      sbuf[5'(sp + 5'h01)] = dig[7:0];
      sp = 5'(sp + 5'h02);
    end
    for (int i = 0; i < srf_pkg::NUM_ANALOG; i++) begin
      if (m[srf_pkg::ANALOG_LSB + i]) begin
        sbuf[sp]             = SMP_ANALOG[16*i+8 +: 8];
        sbuf[5'(sp + 5'h01)] = SMP_ANALOG[16*i +: 8];
        sp = 5'(sp + 5'h02);
      end
    end
    lw = 16'(sp) - 16'(srf_pkg::OFF_TYPE);
    sbuf[srf_pkg::OFF_LEN_HI] = lw[15:8];
    sbuf[srf_pkg::OFF_LEN_LO] = lw[7:0];

    // Command response image.
    cbuf[srf_pkg::OFF_START]       = srf_pkg::START_MARKER;
    cbuf[srf_pkg::OFF_TYPE]        = srf_pkg::TYPE_CMD_RESP;
    cbuf[srf_pkg::OFF_CMD_ID]      = CMD_FRAME_ID;
    cbuf[srf_pkg::OFF_CMD_NAME]    = CMD_NAME[15:8];
    cbuf[srf_pkg::OFF_CMD_NAME+1]  = CMD_NAME[7:0];
    cbuf[srf_pkg::OFF_CMD_STATUS]  = {6'h00, CMD_STATUS};
    cp = srf_pkg::OFF_CMD_DATA;
    // A set carries no data; a query returns the value held.
    dlen = CMD_IS_SET ? 4'h0 : CMD_DATA_LEN;
    for (int i = 0; i < srf_pkg::CMD_DATA_MAX; i++) begin
      if (4'(i) < dlen) begin
        cbuf[cp] = CMD_DATA[63-8*i -: 8];
        cp = 5'(cp + 5'h01);
      end
    end
    lw = 16'(cp) - 16'(srf_pkg::OFF_TYPE);
    cbuf[srf_pkg::OFF_LEN_HI] = lw[15:8];
    cbuf[srf_pkg::OFF_LEN_LO] = lw[7:0];

    smp_ok = st.api_mode
             && (st.legacy_out == srf_pkg::LEGACY_SHORT)
             && (SMP_SRC_SHORT_SETTING == srf_pkg::SHORT_ADDR_OFF);
    slot = !st.tx_valid || TX_READY;

    case (st.phase)
      srf_pkg::SRF_IDLE: begin
        // Commands win a tie; a sample held high is taken next time.
        cmd_take = CMD_REQ;
        smp_take = SMP_REQ && !CMD_REQ;
        if (cmd_take) begin
          // Every taken request with a nonzero identifier is framed,
          // so one request may be answered by several responses.
          if (CMD_FRAME_ID != 8'h00) begin
            next_st.frame  = cbuf;
            next_st.len    = cp;
            next_st.is_smp = 1'b0;
            next_st.phase  = srf_pkg::SRF_SEND;
          end else begin
            next_st.dropped = 8'(st.dropped + 8'h01);
          end
        end else if (smp_take) begin
          if (smp_ok) begin
            next_st.frame  = sbuf;
            next_st.len    = sp;
            next_st.is_smp = 1'b1;
            next_st.phase  = srf_pkg::SRF_SEND;
          end else begin
            next_st.dropped = 8'(st.dropped + 8'h01);
          end
        end
        next_st.cnt = '0;
        next_st.sum = '0;
      end
      srf_pkg::SRF_SEND: begin
        if (slot) begin
          b = st.frame[st.cnt];
          next_st.tx_data  = b;
          next_st.tx_valid = 1'b1;
          if (st.cnt >= srf_pkg::OFF_TYPE) begin
            next_st.sum = 8'(st.sum + b);
          end
          next_st.cnt = 5'(st.cnt + 5'h01);
          if (5'(st.cnt + 5'h01) == st.len) begin
            next_st.phase = srf_pkg::SRF_CSUM;
          end
        end
      end
      srf_pkg::SRF_CSUM: begin
        if (slot) begin
          next_st.tx_data  = 8'(srf_pkg::CSUM_BASE - st.sum);
          next_st.tx_valid = 1'b1;
          next_st.sent     = 8'(st.sent + 8'h01);
          next_st.phase    = srf_pkg::SRF_DRAIN;
        end
      end
      srf_pkg::SRF_DRAIN: begin
        if (TX_READY) begin
          next_st.tx_valid = 1'b0;
          next_st.phase    = srf_pkg::SRF_IDLE;
        end
      end
      default: begin
        next_st.phase    = srf_pkg::SRF_IDLE;
        next_st.tx_valid = 1'b0;
      end
    endcase
    next_st.ready = (next_st.phase == srf_pkg::SRF_IDLE);

    // Register port.
    if (REG_WR) begin
      if (REG_ADDR == srf_pkg::ADDR_CONFIG) begin
        next_st.api_mode   = REG_WDATA[srf_pkg::CFG_API_BIT];
        next_st.legacy_out = REG_WDATA[srf_pkg::CFG_LEGACY_LSB +: 8];
      end
    end
    next_st.rd_data = '0;
    if (REG_RD) begin
      if (REG_ADDR == srf_pkg::ADDR_CONFIG) begin
        next_st.rd_data[srf_pkg::CFG_API_BIT]       = st.api_mode;
        next_st.rd_data[srf_pkg::CFG_LEGACY_LSB +: 8] = st.legacy_out;
      end else if (REG_ADDR == srf_pkg::ADDR_STATUS) begin
        next_st.rd_data[srf_pkg::STS_BUSY_BIT] =
          (st.phase != srf_pkg::SRF_IDLE);
        next_st.rd_data[srf_pkg::STS_SENT_LSB +: 8] = st.sent;
        next_st.rd_data[srf_pkg::STS_DROP_LSB +: 8] = st.dropped;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      st            <= '0;
      st.phase      <= srf_pkg::SRF_IDLE;
      st.ready      <= 1'b1;
      st.api_mode   <= srf_pkg::CFG_API_RESET;
      st.legacy_out <= srf_pkg::CFG_LEG_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign TX_DATA   = st.tx_data;
  assign TX_VALID  = st.tx_valid;
  assign SMP_READY = st.ready;
  assign CMD_READY = st.ready;
  assign REG_RDATA = st.rd_data;

  // Checking aids: an independent byte position and running sum.
  logic [4:0] out_pos;
  logic [7:0] chk_sum;
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      out_pos <= '0;
      chk_sum <= '0;
    end else if (TX_VALID && TX_READY) begin
      if (st.phase == srf_pkg::SRF_DRAIN) begin
        out_pos <= '0;
        chk_sum <= '0;
      end else begin
        out_pos <= 5'(out_pos + 5'h01);
        if (out_pos >= srf_pkg::OFF_TYPE) begin
          chk_sum <= 8'(chk_sum + TX_DATA);
        end
      end
    end
  end

  sequence s_cmd_taken;
    st.ready && CMD_REQ && CMD_FRAME_ID != 8'h00;
  endsequence
  sequence s_smp_taken;
    st.ready && SMP_REQ && !CMD_REQ && st.api_mode
      && st.legacy_out == srf_pkg::LEGACY_SHORT
      && SMP_SRC_SHORT_SETTING == srf_pkg::SHORT_ADDR_OFF;
  endsequence
  sequence s_marker_out;
    TX_VALID && TX_DATA == srf_pkg::START_MARKER && out_pos == 5'h00;
  endsequence

  a_report_starts: assert property (
    s_smp_taken |-> ##[2:3] s_marker_out)
    else $error("Taken sample report did not start a frame.");
  a_marker_first: assert property (
    TX_VALID && out_pos == 5'h00 |-> TX_DATA == srf_pkg::START_MARKER)
    else $error("First frame byte is not the start marker.");
  a_type_byte: assert property (
    TX_VALID && out_pos == srf_pkg::OFF_TYPE |-> TX_DATA ==
      (st.is_smp ? srf_pkg::TYPE_SAMPLE : srf_pkg::TYPE_CMD_RESP))
    else $error("Frame type byte is wrong.");
  a_length_low: assert property (
    TX_VALID && out_pos == srf_pkg::OFF_LEN_LO
      |-> TX_DATA == 8'(st.len - srf_pkg::OFF_TYPE))
    else $error("Length field does not match the payload.");
  a_checksum_ok: assert property (
    TX_VALID && st.phase == srf_pkg::SRF_DRAIN
      |-> TX_DATA == 8'(srf_pkg::CSUM_BASE - chk_sum))
    else $error("Checksum byte is wrong.");
  a_zero_id_quiet: assert property (
    st.ready && CMD_REQ && CMD_FRAME_ID == 8'h00
      |=> st.phase == srf_pkg::SRF_IDLE ##1 !TX_VALID)
    else $error("Response sent for a zero frame identifier.");
  a_api_gate: assert property (
    st.ready && SMP_REQ && !CMD_REQ && !st.api_mode
      |=> st.phase == srf_pkg::SRF_IDLE)
    else $error("Sample report framed outside API mode.");
  a_id_echo: assert property (
    st.ready && CMD_REQ && CMD_FRAME_ID != 8'h00
      |=> st.frame[srf_pkg::OFF_CMD_ID] == $past(CMD_FRAME_ID))
    else $error("Frame identifier not echoed.");
  a_set_no_data: assert property (
    st.ready && CMD_REQ && CMD_IS_SET && CMD_FRAME_ID != 8'h00
      |=> st.len == srf_pkg::OFF_CMD_DATA)
    else $error("Set command response carries data.");
  a_byte_held: assert property (
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("Byte changed while the host stalled.");
  a_read_timing: assert property (
    REG_RD && REG_ADDR == srf_pkg::ADDR_CONFIG
      |=> REG_RDATA[srf_pkg::CFG_LEGACY_LSB +: 8] == $past(st.legacy_out))
    else $error("Configuration read back wrong.");
  a_length_high: assert property (
    TX_VALID && out_pos == srf_pkg::OFF_LEN_HI |-> TX_DATA == 8'h00)
    else $error("Length high byte is not zero.");
  a_source_addr: assert property (
    s_smp_taken |=>
      {st.frame[srf_pkg::OFF_SMP_ADDR], st.frame[srf_pkg::OFF_SMP_ADDR+1]}
        == $past(SMP_SRC_ADDR))
    else $error("Sender address not placed at offset 4.");
  a_rssi_byte: assert property (
    s_smp_taken |=> st.frame[srf_pkg::OFF_SMP_RSSI] == $past(SMP_RSSI))
    else $error("Signal strength byte is wrong.");
  a_option_bits: assert property (
    s_smp_taken |=> st.frame[srf_pkg::OFF_SMP_OPT]
      == {5'h00, $past(SMP_OPTIONS[2:1]), 1'h0})
    else $error("Options byte is wrong.");
  a_sample_count: assert property (
    s_smp_taken |=> st.frame[srf_pkg::OFF_SMP_COUNT] == $past(SMP_COUNT))
    else $error("Sample set count is wrong.");
  a_mask_unused: assert property (
    TX_VALID && st.is_smp && out_pos == srf_pkg::OFF_SMP_MASK
      |-> TX_DATA[7:5] == 3'h0)
    else $error("Unused mask bits are set.");
  a_digital_clean: assert property (
    s_smp_taken ##0 (SMP_MASK[8:0] != 9'h000) |=>
      {st.frame[srf_pkg::OFF_SMP_DIG], st.frame[srf_pkg::OFF_SMP_DIG+1]}
        == ($past(SMP_DIGITAL) & {7'h00, $past(SMP_MASK[8:0])}))
    else $error("Digital word carries lines outside the mask.");
  a_analog_first: assert property (
    s_smp_taken ##0 (SMP_MASK[9:0] == 10'h200) |=>
      {st.frame[srf_pkg::OFF_SMP_DIG], st.frame[srf_pkg::OFF_SMP_DIG+1]}
        == $past(SMP_ANALOG[15:0]))
    else $error("Analog input zero is not first.");
  a_name_echo: assert property (
    s_cmd_taken |=>
      {st.frame[srf_pkg::OFF_CMD_NAME], st.frame[srf_pkg::OFF_CMD_NAME+1]}
        == $past(CMD_NAME))
    else $error("Command name not echoed.");
  a_status_code: assert property (
    s_cmd_taken |=> st.frame[srf_pkg::OFF_CMD_STATUS]
      == {6'h00, $past(CMD_STATUS)})
    else $error("Status byte is wrong.");
  a_query_length: assert property (
    s_cmd_taken ##0 !CMD_IS_SET |=> st.len == 5'(srf_pkg::OFF_CMD_DATA
      + (($past(CMD_DATA_LEN) > 4'h8) ? 4'h8 : $past(CMD_DATA_LEN))))
    else $error("Query response data length is wrong.");

endmodule : srf_framer

// >>> shared/srf_pkg.sv
package srf_pkg;
  // Framing bytes and type codes.
  localparam logic [7:0]  START_MARKER   = 8'h7E;
  localparam logic [7:0]  TYPE_SAMPLE    = 8'h83;
  localparam logic [7:0]  TYPE_CMD_RESP  = 8'h88;
  localparam logic [7:0]  CSUM_BASE      = 8'hFF;
  // Byte offsets inside a frame.
  localparam logic [4:0]  OFF_START      = 5'h00;
  localparam logic [4:0]  OFF_LEN_HI     = 5'h01;
  localparam logic [4:0]  OFF_LEN_LO     = 5'h02;
  localparam logic [4:0]  OFF_TYPE       = 5'h03;
  localparam logic [4:0]  OFF_SMP_ADDR   = 5'h04;
  localparam logic [4:0]  OFF_SMP_RSSI   = 5'h06;
  localparam logic [4:0]  OFF_SMP_OPT    = 5'h07;
  localparam logic [4:0]  OFF_SMP_COUNT  = 5'h08;
  localparam logic [4:0]  OFF_SMP_MASK   = 5'h09;
  localparam logic [4:0]  OFF_SMP_DIG    = 5'h0B;
  localparam logic [4:0]  OFF_CMD_ID     = 5'h04;
  localparam logic [4:0]  OFF_CMD_NAME   = 5'h05;
  localparam logic [4:0]  OFF_CMD_STATUS = 5'h07;
  localparam logic [4:0]  OFF_CMD_DATA   = 5'h08;
  localparam int          BUF_BYTES      = 24;
  localparam int          NUM_ANALOG     = 4;
  localparam int          ANALOG_LSB     = 9;
  localparam int          CMD_DATA_MAX   = 8;
  // Field masks.
  localparam logic [7:0]  OPT_KEEP       = 8'h06;
  localparam logic [15:0] MASK_VALID     = 16'h1FFF;
  localparam logic [15:0] MASK_DIGITAL   = 16'h01FF;
  // Gate for the short-source report.
  localparam logic [7:0]  LEGACY_SHORT   = 8'h02;
  localparam logic [15:0] SHORT_ADDR_OFF = 16'hFFFE;
  // Register map and fields.
  localparam logic [7:0]  ADDR_CONFIG    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h04;
  localparam int          CFG_API_BIT    = 0;
  localparam int          CFG_LEGACY_LSB = 8;
  localparam int          STS_BUSY_BIT   = 0;
  localparam int          STS_SENT_LSB   = 8;
  localparam int          STS_DROP_LSB   = 16;
  localparam logic        CFG_API_RESET  = 1'b0;
  localparam logic [7:0]  CFG_LEG_RESET  = 8'h00;
  // Command outcome codes.
  typedef enum logic [1:0] {
    SRF_OK       = 2'h0,
    SRF_ERROR    = 2'h1,
    SRF_BAD_CMD  = 2'h2,
    SRF_BAD_PARM = 2'h3
  } srf_status_e;
  // Framer phases, one-hot.
  typedef enum logic [3:0] {
    SRF_IDLE  = 4'h1,
    SRF_SEND  = 4'h2,
    SRF_CSUM  = 4'h4,
    SRF_DRAIN = 4'h8
  } srf_phase_e;
endpackage : srf_pkg

// >>> tb/srf_host.sv
`timescale 1ns/100ps
module srf_host (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // Byte stream from the framer
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       slow,
  output logic            tx_ready
);
  logic [7:0] rx_q[$];
  logic [7:0] cur[$];
  int         n_bad = 0;
  int         seed  = 25;
  int         sum;
  initial tx_ready = 1'b0;
  // A slow host stalls at random so that held bytes are exercised too.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      cur.delete();
    end else if (tx_valid && tx_ready) begin
      rx_q.push_back(tx_data);
      cur.push_back(tx_data);
      if (cur.size() > 3 && cur.size() == int'(cur[2]) + 4) begin
        sum = 0;
        foreach (cur[i]) if (i >= 3) sum += cur[i];
        if (cur[0] !== 8'h7E || cur[1] !== 8'h00
            || sum[7:0] !== 8'hFF) begin
          n_bad++;
        end
        cur.delete();
      end
    end
    tx_ready <= !slow || (($random(seed) & 1) != 0);
  end
endmodule : srf_host

// >>> tb/tb_srf_framer.sv
`timescale 1ns/100ps
module tb_srf_framer;
  logic        ref_clk, rst_b, reg_wr, reg_rd, smp_req, cmd_req;
  logic        cmd_is_set, slow, smp_ready, cmd_ready, tx_valid, tx_ready;
  logic [7:0]  reg_addr, smp_rssi, smp_options, smp_count, cmd_frame_id;
  logic [7:0]  tx_data;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] smp_src_addr, smp_short, smp_mask, smp_digital, cmd_name;
  logic [63:0] smp_analog, cmd_data;
  logic [1:0]  cmd_status;
  logic [3:0]  cmd_data_len;
  logic [7:0]  rid;
  logic [7:0]  exp_q[$];
  logic [7:0]  pl[$];
  int          n_errors = 0;
  int          num_checks = 0;
  int          seed = 25;
  int          n_sent = 0;
  int          n_drop = 0;

  srf_framer uut (.REF_CLK(ref_clk), .RST_B(rst_b), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .SMP_REQ(smp_req), .SMP_SRC_ADDR(smp_src_addr),
    .SMP_SRC_SHORT_SETTING(smp_short), .SMP_RSSI(smp_rssi),
    .SMP_OPTIONS(smp_options), .SMP_COUNT(smp_count), .SMP_MASK(smp_mask),
    .SMP_DIGITAL(smp_digital), .SMP_ANALOG(smp_analog),
    .SMP_READY(smp_ready), .CMD_REQ(cmd_req), .CMD_FRAME_ID(cmd_frame_id),
    .CMD_NAME(cmd_name), .CMD_STATUS(cmd_status), .CMD_IS_SET(cmd_is_set),
    .CMD_DATA_LEN(cmd_data_len), .CMD_DATA(cmd_data),
    .CMD_READY(cmd_ready), .TX_DATA(tx_data), .TX_VALID(tx_valid),
    .TX_READY(tx_ready));
  srf_host host (.ref_clk(ref_clk), .rst_b(rst_b), .tx_data(tx_data),
    .tx_valid(tx_valid), .slow(slow), .tx_ready(tx_ready));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic chk32(input string what, input logic [31:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk32

  task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : reg_wr_t

  task automatic reg_rd_t(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    chk32("register read", exp, reg_rdata);
  endtask : reg_rd_t

  // Wraps the payload in marker, length and checksum, reps times over.
  task automatic close_frame(input int reps);
    int s;
    s = 0;
    foreach (pl[i]) s += pl[i];
    repeat (reps) begin
      exp_q.push_back(8'h7E);
      exp_q.push_back(8'h00);
      exp_q.push_back(8'(pl.size()));
      foreach (pl[i]) exp_q.push_back(pl[i]);
      exp_q.push_back(8'hFF - 8'(s));
    end
  endtask : close_frame

  // Holding the request over several takes yields several frames.
  task automatic fire(input logic is_cmd, input int takes);
    int t;
    int w;
    t = 0;
    w = 0;
    if (is_cmd) cmd_req <= 1'b1;
    else smp_req <= 1'b1;
    while (t < takes && w < 2000) begin
      @(posedge ref_clk);
      w++;
      if (smp_ready) t++;
    end
    if (t < takes) begin
      n_errors++;
      summarize();
    end
    cmd_req <= 1'b0;
    smp_req <= 1'b0;
    @(posedge ref_clk);
    w = 0;
    while (!smp_ready && w < 2000) begin
      @(posedge ref_clk);
      w++;
    end
    if (w >= 2000) begin
      n_errors++;
      summarize();
    end
    chk32("frame size", exp_q.size(), host.rx_q.size());
    foreach (exp_q[i]) begin
      if (i < host.rx_q.size()) chk32("frame byte", exp_q[i], host.rx_q[i]);
    end
    chk32("valid after frame", 32'h0, {31'h0, tx_valid});
    exp_q.delete();
    host.rx_q.delete();
  endtask : fire

  task automatic cmd_go(input logic [7:0] id, input logic [15:0] nm,
                        input logic st_set, input logic [1:0] st, int reps);
    logic [63:0] dt;
    logic [3:0]  ln;
    dt = {$random(seed), $random(seed)};
    ln = 4'($random(seed));
    cmd_frame_id <= id;
    cmd_name     <= nm;
    cmd_is_set   <= st_set;
    cmd_status   <= st;
    cmd_data_len <= ln;
    cmd_data     <= dt;
    pl = {8'h88, id, nm[15:8], nm[7:0], 8'(st)};
    if (!st_set) begin
      for (int i = 0; i < ln && i < 8; i++) pl.push_back(dt[63-8*i -: 8]);
    end
    if (id != 8'h00) begin
      close_frame(reps);
      n_sent += reps;
    end else begin
      n_drop += reps;
    end
    fire(1'b1, reps);
  endtask : cmd_go

  task automatic smp_go(input logic [15:0] sh, input logic ok, nodig);
    logic [15:0] a, m, d;
    logic [7:0]  r, o, c;
    logic [63:0] an;
    a  = 16'($random(seed));
    m  = 16'($random(seed));
    d  = 16'($random(seed));
    r  = 8'($random(seed));
    o  = 8'($random(seed));
    c  = 8'($random(seed));
    an = {$random(seed), $random(seed)};
    if (nodig) m[8:0] = 9'h000;
    smp_src_addr <= a;
    smp_short    <= sh;
    smp_rssi     <= r;
    smp_options  <= o;
    smp_count    <= c;
    smp_mask     <= m;
    smp_digital  <= d;
    smp_analog   <= an;
    pl = {8'h83, a[15:8], a[7:0], r, o & 8'h06, c, m[15:8] & 8'h1F, m[7:0]};
    d  = d & {7'h00, m[8:0]};
    if (m[8:0] != 9'h000) pl = {pl, d[15:8], d[7:0]};
    for (int k = 0; k < 4; k++) begin
      if (m[9+k]) pl = {pl, an[16*k+8 +: 8], an[16*k +: 8]};
    end
    if (ok) begin
      close_frame(1);
      n_sent++;
    end else begin
      n_drop++;
    end
    fire(1'b0, 1);
  endtask : smp_go

  initial begin
    #400000;
    n_errors++;
    summarize();
  end

  initial begin
    {reg_wr, reg_rd, smp_req, cmd_req, cmd_is_set, slow} = 6'h00;
    {reg_addr, reg_wdata, smp_src_addr, smp_short} = 72'h0;
    {smp_rssi, smp_options, smp_count, smp_mask, smp_digital} = 56'h0;
    {smp_analog, cmd_data, cmd_frame_id, cmd_name} = 152'h0;
    {cmd_status, cmd_data_len} = 6'h00;
    rst_b = 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    chk32("ready after reset", 32'h1, {31'h0, cmd_ready});
    reg_rd_t(8'h00, 32'h0);
    reg_rd_t(8'h0C, 32'h0);
    cmd_go(8'h01, 16'h4E49, 1'b1, 2'h0, 1);
    cmd_go(8'h00, 16'h4E49, 1'b0, 2'h1, 1);
    cmd_go(8'h17, 16'h4E44, 1'b0, 2'h0, 3);
    slow <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rid = 8'($random(seed)) | 8'h01;
      cmd_go(rid, 16'h5450, i[2], 2'(i), 1);
    end
    smp_go(16'hFFFE, 1'b0, 1'b0);
    reg_wr_t(8'h00, 32'h0000_0101);
    smp_go(16'hFFFE, 1'b0, 1'b0);
    reg_wr_t(8'h00, 32'h0000_0201);
    reg_rd_t(8'h00, 32'h0000_0201);
    smp_go(16'h1234, 1'b0, 1'b0);
    for (int i = 0; i < 12; i++) begin
      smp_go(16'hFFFE, 1'b1, !(i % 3));
    end
    slow <= 1'b0;
    reg_rd_t(8'h04, {8'h00, 8'(n_drop), 8'(n_sent), 8'h00});
    chk32("host rejects", 32'h0, host.n_bad);
    summarize();
  end
endmodule : tb_srf_framer
